// *** pkg/fpexc_pkg.sv ***
// Shared constants and types for the floating-point exception flag unit
package fpexc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATE_OFFSET  = 12'h004;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] STATE_RESET   = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int          EXC_EN_BIT    = 9;
  localparam int          FLAG_W        = 8;
  localparam int          INVALID_BIT   = 0;
  localparam int          DIVZERO_BIT   = 1;
  localparam int          UNDERFLOW_BIT = 2;
  localparam int          OVERFLOW_BIT  = 3;
  localparam int          INEXACT_BIT   = 4;
  localparam int          RSVD_LO_BIT   = 5;
  localparam logic [7:0]  FLAG_USED     = 8'h1F;
  localparam int          MAX_CH        = 32;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    FPEXC_OP_ADD, FPEXC_OP_MUL, FPEXC_OP_DIV, FPEXC_OP_REM, FPEXC_OP_SQRT,
    FPEXC_OP_LOG2, FPEXC_OP_SNAN_ONLY, FPEXC_OP_ROUND_INT
  } fpexc_op_t;

  typedef enum logic [2:0] {
    FPEXC_CLS_ZERO, FPEXC_CLS_DENORM, FPEXC_CLS_FINITE, FPEXC_CLS_INF,
    FPEXC_CLS_QNAN, FPEXC_CLS_SNAN
  } fpexc_class_t;

  typedef enum logic [1:0] {
    round_nearest_even, round_toward_plus, round_toward_minus, round_toward_zero
  } fpexc_round_t;

  typedef enum logic [2:0] {
    FPEXC_RES_ROUNDED, FPEXC_RES_QNAN, FPEXC_RES_INF, FPEXC_RES_FMAX, FPEXC_RES_ZERO
  } fpexc_kind_t;

  // Per-channel facts handed over by the datapath
  typedef struct packed {
    fpexc_op_t    op;
    fpexc_class_t src0Cls;
    logic         src0Neg;
    fpexc_class_t src1Cls;
    logic         src1Neg;
    logic         altMode;
    logic         singlePrec;
    fpexc_round_t roundMode;
    logic         resultNeg;
    logic         overMax;
    logic         tinyNonzero;
    logic         boundedDiffers;
    logic         flushDenorm;
    logic         roundDiffers;
  } fpexc_chan_t;

  typedef struct packed {
    fpexc_kind_t kind;
    logic        neg;
  } fpexc_res_t;

endpackage

// *** design/fpexc_unit.sv ***
// Floating-point exception detection and sticky flag registers
//
// Contract
// (RL1) Flags update only while control bit 9 set
// (RL2) Software sets enable bit at thread start
// (RL3) Hardware only sets flags, never clears them
// (RL4) No handler transfer; flag is the only effect
// (RL5) Both words cleared at reset, thread load; RW
// (RL6) Flags bits 7:0; bits 7:5 reserved
// (RL7) One flag set per thread, all channels share
// (RL8) sNaN or undefined operands: invalid, quiet NaN
// (RL9) Listed undefined operand combinations raise invalid
// (RL10) Square root of negative zero: no flags
// (RL11) sNaN-only ops; single under alternate mode exempt
// (RL12) Nonzero over zero: divide-by-zero, signed infinity
// (RL13) Log2 of zero: divide-by-zero, negative infinity
// (RL14) Overflow when rounded unbounded result exceeds max
// (RL15) Overflow output by sign and rounding mode
// (RL16) Tininess judged after rounding
// (RL17) Flushed tiny result is zero, no underflow
// (RL18) Underflow only when bounded result differs
// (RL19) Inexact when delivered result differs
// (RL20) Infinity and NaN results never inexact
// (RL21) Flushing a denormal always sets inexact
// (RL22) Round-to-integral instructions never set inexact
// (RL23) Channel indications ORed, merged at completion
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module fpexc_unit #(
  parameter int NUM_CH = 32
) (
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [fpexc_pkg::ADDR_W-1:0]             paddr,
  input  wire logic [fpexc_pkg::DATA_W-1:0]             pwdata,
  output logic      [fpexc_pkg::DATA_W-1:0]             prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  input  wire logic                                     threadLoad,
  input  wire logic                                     instrDone,
  input  wire logic [NUM_CH-1:0]                        chanActive,
  input  wire fpexc_pkg::fpexc_chan_t [NUM_CH-1:0]      chanIn,
  output fpexc_pkg::fpexc_res_t [NUM_CH-1:0]            chanResult,
  output logic                                          resultValid,
  output logic      [fpexc_pkg::FLAG_W-1:0]             excFlags,
  output logic                                          excEnable
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // Refused at elaboration so a bad lane count never builds
  if (NUM_CH < 1 || NUM_CH > fpexc_pkg::MAX_CH) begin : gBadNumCh
    $error("fpexc_unit: NUM_CH out of range");
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [fpexc_pkg::DATA_W-1:0] ctrlWord;
  logic [fpexc_pkg::DATA_W-1:0] stateWord;
  logic                         setupPhase;
  logic                         accessDone;
  logic                         wrCtrl;
  logic                         wrState;
  logic                         hitCtrl;
  logic                         hitState;

  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign hitCtrl    = (paddr == fpexc_pkg::CTRL_OFFSET);
  assign hitState   = (paddr == fpexc_pkg::STATE_OFFSET);
  assign wrCtrl     = accessDone && pwrite && hitCtrl;
  assign wrState    = accessDone && pwrite && hitState;

  // Zero-wait answer prepared during setup so every output is a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= fpexc_pkg::ZERO_WORD;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !hitCtrl && !hitState;
      if (setupPhase && !pwrite && hitCtrl) begin
        prdata <= ctrlWord;
      end else if (setupPhase && !pwrite && hitState) begin
        prdata <= stateWord;
      end else if (setupPhase) begin
        prdata <= fpexc_pkg::ZERO_WORD;
      end
    end
  end

  // ****************************************************************
  // Per-channel detection
  // ****************************************************************
  logic [fpexc_pkg::FLAG_W-1:0] chanExc [NUM_CH];
  fpexc_pkg::fpexc_res_t        next_chanResult [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gChan
      fpexc_pkg::fpexc_chan_t c;
      logic s0Zero, s1Zero, s0Inf, s1Inf, s0Nz, nanIn, snanIn, binary, arith;
      logic invSpec, inv, divz, ovf, unf, inexact;
      assign c      = chanIn[g];
      assign s0Zero = (c.src0Cls == fpexc_pkg::FPEXC_CLS_ZERO);
      assign s1Zero = (c.src1Cls == fpexc_pkg::FPEXC_CLS_ZERO);
      assign s0Inf  = (c.src0Cls == fpexc_pkg::FPEXC_CLS_INF);
      assign s1Inf  = (c.src1Cls == fpexc_pkg::FPEXC_CLS_INF);
      assign s0Nz   = (c.src0Cls == fpexc_pkg::FPEXC_CLS_FINITE) || (c.src0Cls == fpexc_pkg::FPEXC_CLS_DENORM);
      assign binary = (c.op == fpexc_pkg::FPEXC_OP_ADD) || (c.op == fpexc_pkg::FPEXC_OP_MUL)
                   || (c.op == fpexc_pkg::FPEXC_OP_DIV) || (c.op == fpexc_pkg::FPEXC_OP_REM);
      assign arith  = (c.op != fpexc_pkg::FPEXC_OP_SNAN_ONLY) && (c.op != fpexc_pkg::FPEXC_OP_ROUND_INT);
      assign snanIn = (c.src0Cls == fpexc_pkg::FPEXC_CLS_SNAN)
                   || (binary && c.src1Cls == fpexc_pkg::FPEXC_CLS_SNAN);
      assign nanIn  = snanIn || (c.src0Cls == fpexc_pkg::FPEXC_CLS_QNAN)
                   || (binary && c.src1Cls == fpexc_pkg::FPEXC_CLS_QNAN);

      // (RL9) Undefined operand combinations
      always_comb begin
        unique case (c.op)
          fpexc_pkg::FPEXC_OP_ADD:  invSpec = s0Inf && s1Inf && (c.src0Neg != c.src1Neg);
          fpexc_pkg::FPEXC_OP_MUL:  invSpec = (s0Zero && s1Inf) || (s0Inf && s1Zero);
          fpexc_pkg::FPEXC_OP_DIV:  invSpec = (s0Zero && s1Zero) || (s0Inf && s1Inf);
          fpexc_pkg::FPEXC_OP_REM:  invSpec = s1Zero || s0Inf;
          // (RL10) Negative zero is not negative nonzero
          fpexc_pkg::FPEXC_OP_SQRT: invSpec = c.src0Neg && (s0Nz || s0Inf);
          default:                  invSpec = 1'b0;
        endcase
      end

      // (RL11) sNaN invalid, alternate mode single exempt
      assign inv  = invSpec || (snanIn && !(c.altMode && c.singlePrec));
      // (RL12) (RL13) Division by zero cases
      assign divz = !nanIn && (((c.op == fpexc_pkg::FPEXC_OP_DIV) && s0Nz && s1Zero)
                   || ((c.op == fpexc_pkg::FPEXC_OP_LOG2) && s0Zero));
      // (RL14) Overflow judged on rounded unbounded magnitude
      assign ovf  = arith && !nanIn && !inv && !divz && c.overMax;
      // (RL16) (RL17) (RL18) Tininess after rounding, flush hides underflow
      assign unf  = arith && !nanIn && !inv && !divz && !ovf && c.tinyNonzero
                 && !c.flushDenorm && c.boundedDiffers;

      always_comb begin
        next_chanResult[g].neg  = c.resultNeg;
        next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_ROUNDED;
        if (inv || nanIn) begin
          // (RL8) Quiet NaN result
          next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_QNAN;
        end else if (divz) begin
          next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_INF;
          next_chanResult[g].neg  = (c.op == fpexc_pkg::FPEXC_OP_LOG2) ? 1'b1 : (c.src0Neg ^ c.src1Neg);
        end else if (ovf) begin
          // (RL15) Infinity or max finite by sign and mode
          if (c.roundMode == fpexc_pkg::round_nearest_even
              || (c.roundMode == fpexc_pkg::round_toward_plus && !c.resultNeg)
              || (c.roundMode == fpexc_pkg::round_toward_minus && c.resultNeg)) begin
            next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_INF;
          end else begin
            next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_FMAX;
          end
        end else if (arith && c.tinyNonzero && c.flushDenorm) begin
          // (RL17) Flushed tiny result delivered as zero
          next_chanResult[g].kind = fpexc_pkg::FPEXC_RES_ZERO;
        end
      end

      // (RL19) (RL20) (RL21) (RL22) Inexact decision
      assign inexact = (c.op != fpexc_pkg::FPEXC_OP_ROUND_INT)
                    && (next_chanResult[g].kind != fpexc_pkg::FPEXC_RES_INF)
                    && (next_chanResult[g].kind != fpexc_pkg::FPEXC_RES_QNAN)
                    && (c.roundDiffers || (arith && c.tinyNonzero && c.flushDenorm));

      always_comb begin
        chanExc[g]                           = '0;
        chanExc[g][fpexc_pkg::INVALID_BIT]   = inv;
        chanExc[g][fpexc_pkg::DIVZERO_BIT]   = divz;
        chanExc[g][fpexc_pkg::UNDERFLOW_BIT] = unf;
        chanExc[g][fpexc_pkg::OVERFLOW_BIT]  = ovf;
        chanExc[g][fpexc_pkg::INEXACT_BIT]   = inexact;
      end
    end
  endgenerate

  // ****************************************************************
  // Merge across channels
  // ****************************************************************
  logic [fpexc_pkg::FLAG_W-1:0] instrExc;
  logic [fpexc_pkg::FLAG_W-1:0] flagSet;

  // (RL23) OR of active channels at completion
  always_comb begin
    instrExc = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (chanActive[i]) begin
        instrExc = instrExc | chanExc[i];
      end
    end
  end

  // (RL1) Events only land while enabled
  assign flagSet = (instrDone && ctrlWord[fpexc_pkg::EXC_EN_BIT]) ? instrExc : '0;

  // Results are informational; no control redirection ever happens
  // (RL4) Exceptions only report, no trap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resultValid <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        chanResult[i] <= '0;
      end
    end else begin
      resultValid <= instrDone;
      for (int i = 0; i < NUM_CH; i++) begin
        chanResult[i] <= next_chanResult[i];
      end
    end
  end

  // ****************************************************************
  // Control and state words
  // ****************************************************************
  // (RL5) Reset and thread load clear the control word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrlWord <= fpexc_pkg::CTRL_RESET;
    end else if (threadLoad) begin
      ctrlWord <= fpexc_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrlWord <= pwdata;
    end
  end

  // Set beats a same-cycle software clear so no event is lost
  // (RL3) (RL5) (RL6) (RL7) Sticky shared flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateWord <= fpexc_pkg::STATE_RESET;
    end else if (threadLoad) begin
      stateWord <= fpexc_pkg::STATE_RESET;
    end else if (wrState) begin
      stateWord <= {pwdata[fpexc_pkg::DATA_W-1:fpexc_pkg::FLAG_W],
                    (pwdata[fpexc_pkg::FLAG_W-1:0] | flagSet) & fpexc_pkg::FLAG_USED};
    end else begin
      stateWord[fpexc_pkg::FLAG_W-1:0] <= stateWord[fpexc_pkg::FLAG_W-1:0] | flagSet;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      excFlags  <= '0;
      excEnable <= 1'b0;
    end else begin
      excFlags  <= stateWord[fpexc_pkg::FLAG_W-1:0];
      excEnable <= ctrlWord[fpexc_pkg::EXC_EN_BIT];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [fpexc_pkg::FLAG_W-1:0] flags;
  assign flags = stateWord[fpexc_pkg::FLAG_W-1:0];

  flag_sticky_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL3)
    !threadLoad && !wrState |=> (flags & $past(flags)) == $past(flags))
    else $error("flag bit cleared by hardware");

  enable_gate_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL1)
    !ctrlWord[fpexc_pkg::EXC_EN_BIT] && !threadLoad && !wrState |=> $stable(flags))
    else $error("flag changed while disabled");

  load_clear_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL5)
    threadLoad |=> stateWord == fpexc_pkg::STATE_RESET && ctrlWord == fpexc_pkg::CTRL_RESET ##1 !excEnable)
    else $error("thread load did not clear words");

  shared_set_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL7)
    instrDone && ctrlWord[fpexc_pkg::EXC_EN_BIT] && !threadLoad |=> (flags & $past(instrExc)) == $past(instrExc))
    else $error("channel exception not merged");

  reserved_zero_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL6)
    flags[fpexc_pkg::FLAG_W-1:fpexc_pkg::RSVD_LO_BIT] == '0)
    else $error("reserved flag bit set");

  sqrt_negzero_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL10)
    chanIn[0].op == fpexc_pkg::FPEXC_OP_SQRT && chanIn[0].src0Cls == fpexc_pkg::FPEXC_CLS_ZERO
    && !chanIn[0].roundDiffers |-> chanExc[0] == '0)
    else $error("sqrt of zero raised a flag");

  divzero_inf_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL12)
    chanExc[0][fpexc_pkg::DIVZERO_BIT] |=> chanResult[0].kind == fpexc_pkg::FPEXC_RES_INF)
    else $error("divide by zero without infinity");

  ovf_round_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL15)
    chanExc[0][fpexc_pkg::OVERFLOW_BIT] && chanIn[0].roundMode == fpexc_pkg::round_toward_zero
    |=> chanResult[0].kind == fpexc_pkg::FPEXC_RES_FMAX)
    else $error("toward-zero overflow not max finite");

  flush_zero_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL17)
    chanIn[0].flushDenorm |-> !chanExc[0][fpexc_pkg::UNDERFLOW_BIT])
    else $error("underflow raised under flush");

  roundint_exact_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL22)
    chanIn[0].op == fpexc_pkg::FPEXC_OP_ROUND_INT |-> !chanExc[0][fpexc_pkg::INEXACT_BIT])
    else $error("round instruction raised inexact");

  inf_exact_a : assert property (@(posedge clk) disable iff (!rst_n) // (RL20)
    next_chanResult[0].kind == fpexc_pkg::FPEXC_RES_INF |-> !chanExc[0][fpexc_pkg::INEXACT_BIT])
    else $error("infinite result flagged inexact");

endmodule

// *** tb/fpexc_dp_model.sv ***
// Behavioural model of the datapath that feeds the exception unit
`timescale 1ns/1ps
module fpexc_dp_model #(
  parameter int NUM_CH = 4
) (
  input  wire logic                           clk,
  output logic                                instrDone,
  output logic [NUM_CH-1:0]                   chanActive,
  output fpexc_pkg::fpexc_chan_t [NUM_CH-1:0] chanIn
);
  fpexc_pkg::fpexc_chan_t pend [NUM_CH];
  fpexc_pkg::fpexc_chan_t junk;

  // Idle and inactive lanes carry sNaN overflow facts, so a stray merge shows
  initial begin
    junk = '0;
    junk.op = fpexc_pkg::FPEXC_OP_ADD;
    junk.src0Cls = fpexc_pkg::FPEXC_CLS_SNAN;
    junk.overMax = 1'b1;
    junk.roundDiffers = 1'b1;
    instrDone = 1'b0;
    chanActive = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      chanIn[i] = junk;
      pend[i] = junk;
    end
  end

  task automatic setCh(input int ch, input fpexc_pkg::fpexc_chan_t c);
    pend[ch] = c;
  endtask

  // Facts stand for exactly the completion cycle, then turn to junk
  task automatic fire(input logic [NUM_CH-1:0] mask);
    @(posedge clk);
    instrDone <= 1'b1;
    chanActive <= mask;
    for (int i = 0; i < NUM_CH; i++) begin
      chanIn[i] <= pend[i];
    end
    @(posedge clk);
    instrDone <= 1'b0;
    chanActive <= ~mask;
    for (int i = 0; i < NUM_CH; i++) begin
      chanIn[i] <= junk;
      pend[i] = junk;
    end
  endtask
endmodule

// *** tb/fp_exception_flags_tb.sv ***
// Self-checking bench for the floating-point exception flag unit
`timescale 1ns/1ps
module fp_exception_flags_tb;
  localparam int NCH = 4;
  localparam logic [11:0] CTL = fpexc_pkg::CTRL_OFFSET, STA = fpexc_pkg::STATE_OFFSET;
  localparam fpexc_pkg::fpexc_class_t ZC = fpexc_pkg::FPEXC_CLS_ZERO, FC = fpexc_pkg::FPEXC_CLS_FINITE,
    IC = fpexc_pkg::FPEXC_CLS_INF, QC = fpexc_pkg::FPEXC_CLS_QNAN, SC = fpexc_pkg::FPEXC_CLS_SNAN;
  localparam fpexc_pkg::fpexc_op_t AD = fpexc_pkg::FPEXC_OP_ADD, MU = fpexc_pkg::FPEXC_OP_MUL,
    DV = fpexc_pkg::FPEXC_OP_DIV, RM = fpexc_pkg::FPEXC_OP_REM, SQ = fpexc_pkg::FPEXC_OP_SQRT,
    LG = fpexc_pkg::FPEXC_OP_LOG2, SO = fpexc_pkg::FPEXC_OP_SNAN_ONLY, RI = fpexc_pkg::FPEXC_OP_ROUND_INT;
  localparam fpexc_pkg::fpexc_kind_t KR = fpexc_pkg::FPEXC_RES_ROUNDED, KQ = fpexc_pkg::FPEXC_RES_QNAN,
    KI = fpexc_pkg::FPEXC_RES_INF, KF = fpexc_pkg::FPEXC_RES_FMAX, KZ = fpexc_pkg::FPEXC_RES_ZERO;

  logic                                clk = 1'b0;
  logic                                rst_n = 1'b0;
  logic                                psel = 1'b0;
  logic                                penable = 1'b0;
  logic                                pwrite = 1'b0;
  logic [11:0]                         paddr = 12'h000;
  logic [31:0]                         pwdata = 32'h0000_0000;
  logic                                threadLoad = 1'b0;
  logic [31:0]                         prdata;
  logic                                pready;
  logic                                pslverr;
  logic                                instrDone;
  logic [NCH-1:0]                      chanActive;
  fpexc_pkg::fpexc_chan_t [NCH-1:0]    chanIn;
  fpexc_pkg::fpexc_res_t [NCH-1:0]     chanResult;
  logic                                resultValid;
  logic [7:0]                          excFlags;
  logic                                excEnable;
  int                                  failCount = 0;
  int                                  checks = 0;
  int                                  cycles = 0;

  fpexc_unit #(.NUM_CH(NCH)) dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .threadLoad(threadLoad), .instrDone(instrDone), .chanActive(chanActive), .chanIn(chanIn),
    .chanResult(chanResult), .resultValid(resultValid), .excFlags(excFlags), .excEnable(excEnable));
  fpexc_dp_model #(.NUM_CH(NCH)) dp (.clk(clk), .instrDone(instrDone), .chanActive(chanActive), .chanIn(chanIn));

  always #12.5 clk = ~clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      giveVerdict();
    end
  end

  task automatic giveVerdict();
    $display("Checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Unmapped places answer with an error and read as zero
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk("read data", x, q);
    chk("read error", {31'h0, (a != CTL && a != STA)}, {31'h0, e});
  endtask

  function automatic fpexc_pkg::fpexc_chan_t mk(input fpexc_pkg::fpexc_op_t o, input fpexc_pkg::fpexc_class_t a,
      input logic an, input fpexc_pkg::fpexc_class_t b, input logic bn);
    mk = '0;
    mk.op = o;
    mk.src0Cls = a;
    mk.src0Neg = an;
    mk.src1Cls = b;
    mk.src1Neg = bn;
    // A sum of like signs keeps that sign; products and quotients take the xor
    mk.resultNeg = (o == AD) ? an : an ^ bn;
  endfunction

  // One lane-0 instruction from clean flags; ck selects kind and sign checks
  task automatic op1(input fpexc_pkg::fpexc_chan_t c, input logic [1:0] ck, input fpexc_pkg::fpexc_kind_t k,
      input logic n, input logic [7:0] fl);
    wr(STA, 32'h0000_0000);
    dp.setCh(0, c);
    dp.fire(4'h1);
    #1;
    chk("result valid", 32'h1, {31'h0, resultValid});
    if (ck[0]) chk("result kind", {29'h0, k}, {29'h0, chanResult[0].kind});
    if (ck[1]) chk("result sign", {31'h0, n}, {31'h0, chanResult[0].neg});
    rd(STA, {24'h0, fl});
  endtask

  task automatic testReset();
    chk("flags out", 32'h0, {24'h0, excFlags});
    chk("enable out", 32'h0, {31'h0, excEnable});
    rd(CTL, 32'h0000_0000);
    rd(STA, 32'h0000_0000);
    rd(12'h008, 32'h0000_0000);
    op1(mk(AD, SC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h00);
    $display("Test reset and disabled done");
  endtask

  task automatic testCodes();
    fpexc_pkg::fpexc_chan_t c;
    wr(CTL, 32'h0000_0200);
    rd(CTL, 32'h0000_0200);
    chk("enable out", 32'h1, {31'h0, excEnable});
    op1(mk(AD, SC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(AD, QC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h00);
    op1(mk(AD, IC, 1'b0, IC, 1'b1), 2'b01, KQ, 1'b0, 8'h01);
    // Like-signed infinities add cleanly; the datapath's own result passes through
    op1(mk(AD, IC, 1'b1, IC, 1'b1), 2'b11, KR, 1'b1, 8'h00);
    op1(mk(DV, ZC, 1'b0, ZC, 1'b1), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(DV, IC, 1'b1, IC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(MU, ZC, 1'b0, IC, 1'b1), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(RM, FC, 1'b0, ZC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(RM, IC, 1'b1, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(SQ, FC, 1'b1, ZC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(SQ, ZC, 1'b1, ZC, 1'b0), 2'b00, KZ, 1'b1, 8'h00);
    op1(mk(DV, FC, 1'b0, ZC, 1'b1), 2'b11, KI, 1'b1, 8'h02);
    op1(mk(DV, FC, 1'b1, ZC, 1'b1), 2'b11, KI, 1'b0, 8'h02);
    op1(mk(LG, ZC, 1'b0, ZC, 1'b0), 2'b11, KI, 1'b1, 8'h02);
    op1(mk(LG, ZC, 1'b1, ZC, 1'b0), 2'b11, KI, 1'b1, 8'h02);
    op1(mk(SO, FC, 1'b0, FC, 1'b0), 2'b00, KR, 1'b0, 8'h00);
    op1(mk(SO, SC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    op1(mk(RI, SC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h01);
    c = mk(SO, SC, 1'b0, FC, 1'b0);
    c.altMode = 1'b1;
    c.singlePrec = 1'b1;
    op1(c, 2'b00, KQ, 1'b0, 8'h00);
    $display("Test exception codes done");
  endtask

  task automatic testRounding();
    fpexc_pkg::fpexc_chan_t c;
    logic toInf;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        c = mk(AD, FC, s[0], FC, s[0]);
        c.roundMode = fpexc_pkg::fpexc_round_t'(m);
        c.overMax = 1'b1;
        c.roundDiffers = 1'b1;
        toInf = (m == 0) || (m == 1 && s == 0) || (m == 2 && s == 1);
        op1(c, 2'b11, toInf ? KI : KF, s[0], toInf ? 8'h08 : 8'h18);
      end
    end
    c = mk(MU, FC, 1'b0, FC, 1'b0);
    c.tinyNonzero = 1'b1;
    c.boundedDiffers = 1'b1;
    c.roundDiffers = 1'b1;
    op1(c, 2'b11, KR, 1'b0, 8'h14);
    c.boundedDiffers = 1'b0;
    c.roundDiffers = 1'b0;
    op1(c, 2'b11, KR, 1'b0, 8'h00);
    c.boundedDiffers = 1'b1;
    c.flushDenorm = 1'b1;
    op1(c, 2'b11, KZ, 1'b0, 8'h10);
    c = mk(AD, FC, 1'b0, FC, 1'b0);
    c.roundDiffers = 1'b1;
    op1(c, 2'b11, KR, 1'b0, 8'h10);
    c.op = RI;
    op1(c, 2'b11, KR, 1'b0, 8'h00);
    $display("Test rounding done");
  endtask

  task automatic testSticky();
    fpexc_pkg::fpexc_chan_t c;
    wr(STA, 32'h0000_0000);
    dp.setCh(0, mk(AD, SC, 1'b0, FC, 1'b0));
    dp.fire(4'h1);
    dp.setCh(0, mk(DV, FC, 1'b0, ZC, 1'b0));
    dp.fire(4'h1);
    dp.setCh(0, mk(AD, FC, 1'b0, FC, 1'b0));
    dp.fire(4'h1);
    rd(STA, 32'h0000_0003);
    chk("flags out", 32'h3, {24'h0, excFlags});
    wr(STA, 32'hFFFF_FFFF);
    rd(STA, 32'hFFFF_FF1F);
    wr(STA, 32'h0000_0000);
    rd(STA, 32'h0000_0000);
    c = mk(AD, FC, 1'b0, FC, 1'b0);
    c.overMax = 1'b1;
    dp.setCh(0, mk(AD, FC, 1'b0, FC, 1'b0));
    dp.setCh(1, mk(DV, FC, 1'b0, ZC, 1'b0));
    dp.setCh(2, mk(AD, SC, 1'b0, FC, 1'b0));
    dp.setCh(3, c);
    dp.fire(4'h7);
    rd(STA, 32'h0000_0003);
    $display("Test sticky and channels done");
  endtask

  task automatic testLoad();
    wr(STA, 32'h0000_001F);
    @(posedge clk);
    threadLoad <= 1'b1;
    @(posedge clk);
    threadLoad <= 1'b0;
    rd(CTL, 32'h0000_0000);
    rd(STA, 32'h0000_0000);
    chk("enable out", 32'h0, {31'h0, excEnable});
    wr(CTL, 32'hFFFF_FDFF);
    rd(CTL, 32'hFFFF_FDFF);
    op1(mk(AD, SC, 1'b0, FC, 1'b0), 2'b01, KQ, 1'b0, 8'h00);
    $display("Test thread load done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testCodes();
    testRounding();
    testSticky();
    testLoad();
    giveVerdict();
  end
endmodule
